// [io_bus_checker.sv]
module io_bus_checker #(
  parameter int unsigned WORD_W = io_check_pkg::WORD_W
) (
  // Clock and reset
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_arst_n,
  // Link pins (asynchronous to i_sys_clk)
  input  wire logic                         i_data_clk,
  input  wire logic [WORD_W-1:0]            i_first_input_bus,
  input  wire logic [WORD_W-1:0]            i_second_input_bus,
  input  wire logic                         i_input_strobe,
  input  wire logic                         i_sync,
  input  wire logic                         i_parity,
  input  wire logic                         i_transmit_enable_pin,
  // Control
  input  wire logic                         i_sif_tx_enable,
  input  wire logic                         i_pattern_test_ena,
  input  wire logic                         i_sync_select,
  input  wire logic                         i_single_parity_ena,
  input  wire logic                         i_odd_parity,
  // Key write port
  input  wire logic                         i_key_wr,
  input  wire logic [io_check_pkg::KIDX_W-1:0] i_key_idx,
  input  wire logic [WORD_W-1:0]            i_key_wdata,
  // Status clear port: a 0 written to a bit clears it
  input  wire logic                         i_results_wr,
  input  wire logic [WORD_W-1:0]            i_results_wdata,
  input  wire logic                         i_alarm_wr,
  input  wire logic [io_check_pkg::ALM_W-1:0] i_alarm_wdata,
  // Status and outputs
  output logic      [WORD_W-1:0]            o_pattern_results,
  output logic      [io_check_pkg::ALM_W-1:0] o_alarm_status,
  output logic      [WORD_W-1:0]            o_key_rdata,
  output logic                              o_analog_out_ena
);
  import io_check_pkg::*;

  typedef struct packed {
    logic [2:0]                     clk_s;   // [0] first stage, [1] second, [2] prev
    logic [WORD_W-1:0]              a_s1;
    logic [WORD_W-1:0]              a_s2;
    logic [WORD_W-1:0]              b_s1;
    logic [WORD_W-1:0]              b_s2;
    logic [2:0]                     strb_s;  // two stages plus previous
    logic [2:0]                     sync_s;
    logic [1:0]                     par_s;
    logic [1:0]                     txen_s;
    logic                           armed;
    logic [1:0]                     phase;
    logic [KEY_WORDS*WORD_W-1:0]    key;
    logic [WORD_W-1:0]              results;
    logic [ALM_W-1:0]               alarm;
    logic                           out_ena;
    logic [WORD_W-1:0]              key_rd;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // Helper view of the synchronised link
  logic                clk_rise;
  logic                clk_fall;
  logic                clk_edge;
  logic                marker_rise;
  logic [WORD_W-1:0]   rx_a;
  logic [WORD_W-1:0]   rx_b;
  logic [2:0]          exp_a_idx;
  logic [2:0]          exp_b_idx;
  logic [WORD_W-1:0]   exp_a;
  logic [WORD_W-1:0]   exp_b;
  logic [WORD_W-1:0]   mism;
  logic                par_bad;
  logic [1:0]          use_phase;

  // Edge detection on the second stage only; first stage feeds nothing else
  assign clk_rise    = st_ff.clk_s[1] & ~st_ff.clk_s[2];
  assign clk_fall    = ~st_ff.clk_s[1] & st_ff.clk_s[2];
  assign clk_edge    = clk_rise | clk_fall;
  assign marker_rise = (i_sync_select == SEL_SYNC) ? (st_ff.sync_s[1] & ~st_ff.sync_s[2])
                                                    : (st_ff.strb_s[1] & ~st_ff.strb_s[2]);
  assign rx_a        = st_ff.a_s2;
  assign rx_b        = st_ff.b_s2;

  // A marker coinciding with an edge restarts the sequence at word 0
  assign use_phase = marker_rise ? PH_FIRST : st_ff.phase;

  // Expected key words by phase
  always_comb begin
    unique case (use_phase)
      2'h0: begin
        exp_a_idx = SEQ_A0;
        exp_b_idx = SEQ_B0;
      end
      2'h1: begin
        exp_a_idx = SEQ_A1;
        exp_b_idx = SEQ_B1;
      end
      2'h2: begin
        exp_a_idx = SEQ_A2;
        exp_b_idx = SEQ_B2;
      end
      2'h3: begin
        exp_a_idx = SEQ_A3;
        exp_b_idx = SEQ_B3;
      end
    endcase
  end

  assign exp_a   = st_ff.key[exp_a_idx*WORD_W +: WORD_W];
  assign exp_b   = st_ff.key[exp_b_idx*WORD_W +: WORD_W];
  // Bus identity is deliberately folded away
  assign mism    = (rx_a ^ exp_a) | (rx_b ^ exp_b);
  // Odd total over 33 bits is good when odd parity selected
  assign par_bad = ((^rx_a) ^ (^rx_b) ^ st_ff.par_s[1]) != i_odd_parity;

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    // Two-stage synchronisers; data lines are sampled as a whole bus so the
    // source must hold each word for several system clocks (slow link only)
    nxt_st.clk_s  = {st_ff.clk_s[1:0], i_data_clk};
    nxt_st.a_s1   = i_first_input_bus;
    nxt_st.a_s2   = st_ff.a_s1;
    nxt_st.b_s1   = i_second_input_bus;
    nxt_st.b_s2   = st_ff.b_s1;
    nxt_st.strb_s = {st_ff.strb_s[1], st_ff.strb_s[0], i_input_strobe};
    nxt_st.sync_s = {st_ff.sync_s[1], st_ff.sync_s[0], i_sync};
    nxt_st.par_s  = {st_ff.par_s[0], i_parity};
    nxt_st.txen_s = {st_ff.txen_s[0], i_transmit_enable_pin};

    // Key storage, writable any time
    if (i_key_wr) begin
      nxt_st.key[i_key_idx*WORD_W +: WORD_W] = i_key_wdata;
    end
    nxt_st.key_rd = st_ff.key[i_key_idx*WORD_W +: WORD_W];

    // Software clears first so a same-cycle error wins
    if (i_results_wr) begin
      nxt_st.results = st_ff.results & i_results_wdata;
    end
    if (i_alarm_wr) begin
      nxt_st.alarm = st_ff.alarm & i_alarm_wdata;
    end

    // Pattern sequencing
    if (!i_pattern_test_ena) begin
      nxt_st.armed = 1'b0;
      nxt_st.phase = PH_FIRST;
    end else if (clk_edge) begin
      if (marker_rise || st_ff.armed) begin
        nxt_st.armed = 1'b1;
        nxt_st.phase = use_phase + 2'h1;
        if (|mism) begin
          nxt_st.results     = nxt_st.results | mism;
          nxt_st.alarm[ALM_PAT] = 1'b1;
        end
      end
    end else if (marker_rise) begin
      nxt_st.armed = 1'b1;
      nxt_st.phase = PH_FIRST;
    end

    // Parity per edge; other alarms are not produced here
    if (i_single_parity_ena && par_bad) begin
      if (clk_rise) begin
        nxt_st.alarm[ALM_PRISE] = 1'b1;
      end
      if (clk_fall) begin
        nxt_st.alarm[ALM_PFALL] = 1'b1;
      end
    end

    // Output gating
    nxt_st.out_ena = ~i_pattern_test_ena & st_ff.txen_s[1] & i_sif_tx_enable;
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff     <= '0;
      st_ff.key <= {{(KEY_WORDS-1){KEYN_RST}}, KEY0_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs from flip-flops; in test mode results, pattern and parity bits all update
  assign o_pattern_results = st_ff.results;
  assign o_alarm_status    = st_ff.alarm;
  assign o_key_rdata       = st_ff.key_rd;
  assign o_analog_out_ena  = st_ff.out_ena;

  // Assertions
  AST_OUT_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    i_pattern_test_ena |=> !o_analog_out_ena)
    else $error("analog output enabled during pattern test");

  AST_KEY_WR: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    i_key_wr |=> st_ff.key[$past(i_key_idx)*WORD_W +: WORD_W] == $past(i_key_wdata))
    else $error("key word not written");

  AST_RES_SET: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_pattern_test_ena && clk_edge && st_ff.armed) |=> ((o_pattern_results & $past(mism)) == $past(mism)))
    else $error("mismatch bit not recorded");

  AST_ALM_PAT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_pattern_test_ena && clk_edge && st_ff.armed && |mism) |=> o_alarm_status[ALM_PAT])
    else $error("pattern alarm not raised");

  AST_NO_EARLY: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (!st_ff.armed && !marker_rise) |=> $stable(o_pattern_results) || $past(i_results_wr))
    else $error("results changed before first marker");

  AST_PAR_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_single_parity_ena && par_bad && clk_rise) |=> o_alarm_status[ALM_PRISE] && !$past(clk_fall))
    else $error("rising parity alarm missing");

  AST_PAR_ODD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_single_parity_ena && clk_fall && i_odd_parity && ((^rx_a) ^ (^rx_b) ^ st_ff.par_s[1]))
      |=> o_alarm_status[ALM_PFALL] == $past(o_alarm_status[ALM_PFALL]) || $past(i_alarm_wr))
    else $error("good odd parity flagged");

  AST_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (o_alarm_status[ALM_PAT] && !i_alarm_wr) |=> o_alarm_status[ALM_PAT])
    else $error("alarm dropped without clear");

  // Key storage: words only change on a write strobe
  AST_KEY_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !i_key_wr |=> $stable(st_ff.key))
    else $error("key word changed without write");

  // Frame start always selects the first key pair on both buses
  AST_FRAME_KEYS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_pattern_test_ena && marker_rise) |-> (exp_a_idx == SEQ_A0) && (exp_b_idx == SEQ_B0))
    else $error("frame start not on first key pair");

  // Sequencing: a marker arms and restarts, clearing the test disarms
  AST_ARM: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_pattern_test_ena && marker_rise) |=> st_ff.armed)
    else $error("marker did not arm the checker");

  AST_RESTART: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_pattern_test_ena && marker_rise && clk_edge) |=> (st_ff.phase == PH_FIRST + 2'h1))
    else $error("marker did not restart the sequence");

  AST_DISARM: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !i_pattern_test_ena |=> !st_ff.armed)
    else $error("checker armed while test disabled");

  // Clears: with no link edge in the same cycle the mask applies exactly;
  // on an edge the set path wins, so those cycles are left to the set checks
  AST_RES_CLR: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_results_wr && !clk_edge) |=> (o_pattern_results == ($past(o_pattern_results) & $past(i_results_wdata))))
    else $error("result clear mask not applied");

  AST_ALM_CLR: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_alarm_wr && !clk_edge) |=> (o_alarm_status == ($past(o_alarm_status) & $past(i_alarm_wdata))))
    else $error("alarm clear mask not applied");

  // Sticky behaviour of the result bits and both parity alarm bits
  AST_RES_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !i_results_wr |=> ((o_pattern_results & $past(o_pattern_results)) == $past(o_pattern_results)))
    else $error("result bit dropped without clear");

  AST_PRISE_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (o_alarm_status[ALM_PRISE] && !i_alarm_wr) |=> o_alarm_status[ALM_PRISE])
    else $error("rising parity alarm dropped without clear");

  AST_PFALL_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (o_alarm_status[ALM_PFALL] && !i_alarm_wr) |=> o_alarm_status[ALM_PFALL])
    else $error("falling parity alarm dropped without clear");

  // Only the pattern and parity bits are ever produced here
  AST_OTHER_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_alarm_status[ALM_PAT-1:ALM_PRISE+1] == '0)
    else $error("unused alarm bit set");

  // Parity: falling edge alarm, even selection, and silence when disabled
  AST_PAR_FALL: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_single_parity_ena && par_bad && clk_fall) |=> o_alarm_status[ALM_PFALL])
    else $error("falling parity alarm missing");

  AST_PAR_EVEN: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_single_parity_ena && clk_rise && !i_odd_parity && !((^rx_a) ^ (^rx_b) ^ st_ff.par_s[1]))
      |=> (o_alarm_status[ALM_PRISE] == $past(o_alarm_status[ALM_PRISE])) || $past(i_alarm_wr))
    else $error("good even parity flagged");

  AST_PAR_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (!i_single_parity_ena && !i_alarm_wr) |=> $stable(o_alarm_status[ALM_PRISE:ALM_PFALL]))
    else $error("parity alarm changed while parity disabled");

endmodule : io_bus_checker

// [io_check_pkg.sv]
package io_check_pkg;

  // Key geometry
  localparam int unsigned KEY_WORDS  = 8;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned KIDX_W     = 3;

  // Key reset values; word 0 fixed, the rest arbitrary neutral defaults
  localparam logic [15:0] KEY0_RST   = 16'h7a7a;
  localparam logic [15:0] KEYN_RST   = 16'h0000;

  // Alarm status register layout
  localparam int unsigned ALM_W      = 8;
  localparam int unsigned ALM_PAT    = 7;
  localparam int unsigned ALM_PRISE  = 1;
  localparam int unsigned ALM_PFALL  = 0;

  // Key word sequence per data clock edge (cycle phase 0..3)
  localparam logic [2:0]  SEQ_A0     = 3'h0;
  localparam logic [2:0]  SEQ_A1     = 3'h1;
  localparam logic [2:0]  SEQ_A2     = 3'h4;
  localparam logic [2:0]  SEQ_A3     = 3'h5;
  localparam logic [2:0]  SEQ_B0     = 3'h2;
  localparam logic [2:0]  SEQ_B1     = 3'h3;
  localparam logic [2:0]  SEQ_B2     = 3'h6;
  localparam logic [2:0]  SEQ_B3     = 3'h7;
  localparam logic [1:0]  PH_LAST    = 2'h3;
  localparam logic [1:0]  PH_FIRST   = 2'h0;

  // Frame-marker source selection
  localparam logic        SEL_STROBE = 1'b0;
  localparam logic        SEL_SYNC   = 1'b1;

endpackage : io_check_pkg

// [io_src_model.sv]
module io_src_model (
  // Run control
  input  wire logic         i_go,
  input  wire logic         i_mark,
  input  wire logic         i_sel,
  input  wire logic         i_odd,
  // Fault injection and key table
  input  wire logic [15:0]  i_err,
  input  wire logic [1:0]   i_badp,
  input  wire logic [127:0] i_key,
  // Link pins
  output logic              o_dclk,
  output logic [15:0]       o_a,
  output logic [15:0]       o_b,
  output logic              o_stb,
  output logic              o_sync,
  output logic              o_par,
  output logic              o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int          ia;
  logic [15:0] x;
  logic [15:0] y;
  // Clock idles low; data turns mid-period so it is stable round each edge
  initial begin
    {o_dclk, o_stb, o_sync, o_par, o_busy, o_a, o_b} = '0;
    forever begin
      @(posedge i_go);
      o_busy = 1'b1;
      for (int k = 0; k < 12; k++) begin // Three frames back to back
        ia = (k % 4 < 2) ? k % 4 : k % 4 + 2; // A keys 0,1,4,5; B two above
        x = i_key[16*ia+:16] ^ ((k == 1) ? {8'h00, i_err[7:0]} : 16'h0000);
        y = i_key[16*(ia+2)+:16] ^ ((k == 1) ? {i_err[15:8], 8'h00} : 16'h0000);
        o_a = x;
        o_b = y;
        o_par = ^{x, y} ^ i_odd ^ ((k % 2 == 0) ? i_badp[1] : i_badp[0]);
        #80;
        o_dclk = ~o_dclk; // Both edges carry a word
        if (k == 0 && i_mark) begin
          o_sync = i_sel; // Marker rises with key words 0 and 2
          o_stb  = ~i_sel;
        end
        #80;
      end
      // Released lines must not keep the last value
      o_stb  = 1'b0;
      o_sync = 1'b0;
      o_a    = ~o_a;
      o_b    = ~o_b;
      o_par  = ~o_par;
      o_busy = 1'b0;
    end
  end
endmodule : io_src_model

// [tb_input_bus_pattern_parity_check.sv]
module tb_input_bus_pattern_parity_check;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, pin = 1, sif = 1, ten = 0, ssel = 0, pen = 0, odd = 0;
  logic kwr = 0, rwr = 0, awr = 0, go = 0, mark = 1, dclk, stb, sync, par, busy, aon;
  logic [2:0] kidx = 0;
  logic [1:0] badp = 0;
  logic [7:0] alm, awd = 0;
  logic [15:0] kwd = 0, err = 0, rwd = 0, da, db, res, krd;
  logic [127:0] key = {112'h0, 16'h7a7a};
  int mismatches = 0, tests_run = 0;
  initial forever #20 clk = ~clk;
  io_bus_checker i_dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_data_clk(dclk), .i_first_input_bus(da),
    .i_second_input_bus(db), .i_input_strobe(stb), .i_sync(sync), .i_parity(par), .i_transmit_enable_pin(pin),
    .i_sif_tx_enable(sif), .i_pattern_test_ena(ten), .i_sync_select(ssel), .i_single_parity_ena(pen),
    .i_odd_parity(odd), .i_key_wr(kwr), .i_key_idx(kidx), .i_key_wdata(kwd), .i_results_wr(rwr),
    .i_results_wdata(rwd), .i_alarm_wr(awr), .i_alarm_wdata(awd), .o_pattern_results(res),
    .o_alarm_status(alm), .o_key_rdata(krd), .o_analog_out_ena(aon));
  io_src_model i_src (.i_go(go), .i_mark(mark), .i_sel(ssel), .i_odd(odd), .i_err(err), .i_badp(badp),
    .i_key(key), .o_dclk(dclk), .o_a(da), .o_b(db), .o_stb(stb), .o_sync(sync), .o_par(par), .o_busy(busy));
  task automatic close_out;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Key access through the write pulse and the registered read port
  task automatic kw(input logic [2:0] i, input logic [15:0] v);
    kidx = i;
    kwd = v;
    kwr = 1;
    key[16*i+:16] = v;
    tick(1);
    kwr = 0;
    tick(1);
  endtask : kw
  task automatic kr(input logic [2:0] i, input logic [15:0] e);
    kidx = i;
    tick(2);
    chk(krd, e);
  endtask : kr
  // One burst of frames; bounded wait for the source to finish
  task automatic run(input logic m);
    mark = m;
    go = 1;
    tick(1);
    go = 0;
    for (int n = 0; busy !== 1'b0; n++) begin
      if (n > 300) begin
        mismatches++;
        close_out();
      end
      tick(1);
    end
    tick(8);
  endtask : run
  task automatic clr(input logic [15:0] rm, input logic [7:0] am);
    rwd = rm;
    awd = am;
    rwr = 1;
    awr = 1;
    tick(1);
    rwr = 0;
    awr = 0;
    tick(1);
  endtask : clr
  initial begin
    tick(2);
    rst_n = 1;
    kr(0, 16'h7a7a);
    kr(1, 16'h0000);
    tick(6);
    chk({15'h0, aon}, 16'h0001);
    ten = 1;
    tick(3);
    chk({15'h0, aon}, 16'h0000);
    $display("reset and output enable test done");
    for (int i = 1; i < 8; i++) kw(3'(i), 16'(16'h1357 * i));
    for (int i = 1; i < 8; i++) kr(3'(i), 16'(16'h1357 * i));
    $display("key table test done");
    err = 16'h0001;
    run(0);
    chk(res, 16'h0000);
    $display("unarmed test done");
    // Error on the first bus with strobe, then the second bus with sync
    for (int s = 0; s < 2; s++) begin
      ten = 0;
      tick(2);
      ten = 1;
      ssel = s[0];
      err = s ? 16'h8000 : 16'h0001;
      run(1);
      chk(res, err);
      chk({8'h00, alm}, 16'h0080);
      err = 0;
      run(1);
      chk(res, s ? 16'h8000 : 16'h0001);
      clr(16'hffff, 8'h7f);
      chk(res, s ? 16'h8000 : 16'h0001);
      chk({8'h00, alm}, 16'h0000);
      clr(16'h0000, 8'h00);
      chk(res, 16'h0000);
    end
    // After the full clear an error sets result bit 8
    err = 16'h0100;
    run(1);
    chk(res, 16'h0100);
    chk({8'h00, alm}, 16'h0080);
    clr(16'h0000, 8'h00);
    err = 0;
    $display("pattern test done");
    ten = 0;
    pen = 1;
    for (int o = 0; o < 2; o++) begin
      odd = o[0];
      badp = 0;
      run(1);
      chk({8'h00, alm}, 16'h0000);
      badp = 2'b10;
      run(1);
      chk({8'h00, alm}, 16'h0002);
      clr(16'h0000, 8'h00);
      badp = 2'b01;
      run(1);
      chk({8'h00, alm}, 16'h0001);
      clr(16'h0000, 8'h00);
      chk({8'h00, alm}, 16'h0000);
    end
    $display("parity test done");
    close_out();
  end
endmodule : tb_input_bus_pattern_parity_check
